//--- design/baud_tick_gen.sv
// Sixteen-times sample tick from a divisor, with the fast base when high speed and divisor bit 15 are both set.
// Assumes divisor and high-speed flag are registers on the same clock.
`timescale 1ns/1ps
module baud_tick_gen (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Rate setting
   input wire logic [15:0] divisor,
   input wire logic highSpeed,
   // Tick
   output logic sampleTick
);
   import uart_hs_pkg::*;

   logic fast;
   logic [ACC_W-1:0] acc;
   logic [ACC_W:0] accSum;
   logic baseTick;
   logic [15:0] divide;
   logic [15:0] cnt;
   logic [16:0] cntNext;

   // ***************
   // Base rate
   // ***************
   assign fast = highSpeed && divisor[DIV_FAST_BIT]; // RULE_12 RULE_13
   assign accSum = {1'b0, acc} + (fast ? ACC_STEP_FAST : ACC_STEP_NORMAL); // RULE_01
   assign baseTick = accSum >= ACC_MOD;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         acc <= '0;
      end else if (baseTick) begin
         acc <= ACC_W'(accSum - ACC_MOD);
      end else begin
         acc <= ACC_W'(accSum);
      end
   end

   // ***************
   // Divider
   // ***************
   assign divide = fast ? {1'b0, divisor[DIV_FAST_BIT-1:0]} : divisor;
   assign cntNext = {1'b0, cnt} + 17'h00001;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cnt <= '0;
         sampleTick <= 1'b0;
      end else begin
         sampleTick <= 1'b0;
         if (baseTick && divide != 16'h0000) begin
            if (cntNext >= {1'b0, divide}) begin
               cnt <= '0;
               sampleTick <= 1'b1;
            end else begin
               cnt <= 16'(cntNext);
            end
         end
      end
   end

   // ***************
   // Checks
   // ***************
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);

   a_fast_full: assert property (baseTick && fast && divide == 16'h0001 |=> sampleTick) // RULE_13
      else $error("fast divisor one missed a tick");
   a_fast_half: assert property (baseTick && fast && divide == 16'h0002 && cnt == 16'h0000 // RULE_12
      |=> !sampleTick && cnt == 16'h0001)
      else $error("fast divisor two ticked early");
   a_base_spacing: assert property (baseTick |=> !baseTick) // RULE_01
      else $error("base tick too dense");
   c_fast_tick: cover property (fast && sampleTick);
endmodule

//--- design/cfg_bus_if.sv
// Carrier between the port decoder and the configuration register logic.
// Assumes strobes are one-cycle pulses on the shared clock.
`timescale 1ns/1ps
interface cfg_bus_if;
   logic idxWr;
   logic dataWr;
   logic [7:0] wrData;
   logic [7:0] rdData;
   logic [7:0] indexVal;
   logic [1:0] highSpeed;
   logic active;
   modport ctrl (input idxWr, dataWr, wrData, output rdData, indexVal, highSpeed, active);
   modport host (output idxWr, dataWr, wrData, input rdData, indexVal, highSpeed, active);
endinterface

//--- design/config_port_ctrl.sv
// Index/data configuration registers guarded by enter and exit keys.
// Assumes strobes arrive decoded from the port decoder on the same clock.
`timescale 1ns/1ps
module config_port_ctrl (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Decoded port strobes
   cfg_bus_if.ctrl cfg
);
   import uart_hs_pkg::*;

   typedef enum logic {CFG_LOCKED, CFG_OPEN} cfg_state_t;

   cfg_state_t state;
   logic [7:0] index;
   logic [7:0] ldn;
   logic [7:0] mode [CH_COUNT];
   logic open;

   function automatic logic ldnValid(input logic [7:0] n);
      return (n == LDN_CH3) || (n == LDN_CH4);
   endfunction

   function automatic logic ldnChan(input logic [7:0] n);
      return n == LDN_CH4;
   endfunction

   assign open = state == CFG_OPEN;

   // ***************
   // Key sequence
   // ***************
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state <= CFG_LOCKED;
      end else if (cfg.idxWr) begin
         case (state)
            CFG_LOCKED: if (cfg.wrData == KEY_ENTER) state <= CFG_OPEN; // RULE_03
            CFG_OPEN: if (cfg.wrData == KEY_EXIT) state <= CFG_LOCKED; // RULE_09
            default: state <= CFG_LOCKED;
         endcase
      end
   end

   // ***************
   // Index and device number
   // ***************
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         index <= RD_EMPTY;
      end else if (open && cfg.idxWr && cfg.wrData != KEY_EXIT) begin
         index <= cfg.wrData; // RULE_04
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ldn <= LDN_RESET;
      end else if (open && cfg.dataWr && index == IDX_LDN) begin
         ldn <= cfg.wrData; // RULE_05
      end
   end

   // ***************
   // Mode registers
   // ***************
   for (genvar i = 0; i < CH_COUNT; i++) begin : g_mode
      always_ff @(posedge ref_clk or posedge rst) begin
         if (rst) begin
            mode[i] <= MODE_RESET;
         end else if (open && cfg.dataWr && index == IDX_MODE && ldnValid(ldn) && ldnChan(ldn) == 1'(i)) begin
            mode[i] <= cfg.wrData; // RULE_08 RULE_15
         end
      end
      assign cfg.highSpeed[i] = mode[i][MODE_HS_BIT]; // RULE_07
   end

   always_comb begin
      cfg.rdData = RD_UNMAPPED;
      if (open) begin
         case (index)
            IDX_LDN: cfg.rdData = ldn;
            IDX_MODE: cfg.rdData = ldnValid(ldn) ? mode[ldnChan(ldn)] : RD_EMPTY; // RULE_06
            default: cfg.rdData = RD_EMPTY;
         endcase
      end
   end

   assign cfg.indexVal = index;
   assign cfg.active = open;

   // ***************
   // Checks
   // ***************
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);

   a_locked_no_write: assert property (!open && (cfg.idxWr || cfg.dataWr) |=> // RULE_15
      $stable(mode[0]) && $stable(mode[1]) && $stable(ldn) && $stable(index))
      else $error("configuration changed while locked");
   a_ldn_select: assert property (open && cfg.dataWr && index == IDX_LDN |=> ldn == $past(cfg.wrData)) // RULE_05
      else $error("device number not loaded");
   a_mode_update: assert property (open && cfg.dataWr && index == IDX_MODE && ldn == LDN_CH4 // RULE_08
      |=> mode[1] == $past(cfg.wrData) && $stable(mode[0]))
      else $error("mode register of channel four not updated");
   a_mode_read: assert property (open && index == IDX_MODE && ldn == LDN_CH3 |-> cfg.rdData == mode[0]) // RULE_06
      else $error("mode register read wrong");
   a_exit_key: assert property (open && cfg.idxWr && cfg.wrData == KEY_EXIT |=> !open ##1 // RULE_09
      (!open || ($past(cfg.idxWr) && $past(cfg.wrData) == KEY_ENTER)))
      else $error("exit key ignored");
   c_mode_written: cover property (open && cfg.dataWr && index == IDX_MODE && ldnValid(ldn));
endmodule

//--- design/uart_high_speed_baud_config.sv
// Top: I/O port decode, channel divisor and line control, tick generators.
// Assumes the host gives one-cycle read and write strobes on ref_clk.
`timescale 1ns/1ps
module uart_high_speed_baud_config (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Host I/O port access
   input wire logic [uart_hs_pkg::ADDR_W-1:0] ioAddr,
   input wire logic [7:0] ioWrData,
   input wire logic ioWr,
   input wire logic ioRd,
   output logic [7:0] ioRdData,
   output logic ioRdValid,
   // Channel state
   output logic [uart_hs_pkg::CH_COUNT-1:0] sampleTick,
   output logic [uart_hs_pkg::CH_COUNT-1:0] highSpeedEn,
   output logic [uart_hs_pkg::CH_COUNT-1:0][7:0] lineFormat,
   output logic configActive
);
   import uart_hs_pkg::*;

   logic [7:0] lcr [CH_COUNT];
   logic [7:0] divLo [CH_COUNT];
   logic [7:0] divHi [CH_COUNT];
   logic [CH_COUNT-1:0] divisor_latch_access;
   logic [7:0] rdMux;

   cfg_bus_if cfg ();

   function automatic logic chanHit(input logic [15:0] a, input logic [15:0] base, input logic [2:0] ofs);
      return a == (base | {13'h0000, ofs});
   endfunction

   // ***************
   // Configuration ports
   // ***************
   assign cfg.idxWr = ioWr && ioAddr == CFG_INDEX_PORT; // RULE_03 RULE_09
   assign cfg.dataWr = ioWr && ioAddr == CFG_DATA_PORT; // RULE_05 RULE_08
   assign cfg.wrData = ioWrData;

   config_port_ctrl u_cfg (
      .ref_clk(ref_clk),
      .rst(rst),
      .cfg(cfg)
   );

   assign highSpeedEn = cfg.highSpeed;
   assign configActive = cfg.active;

   // ***************
   // Channel registers
   // ***************
   for (genvar c = 0; c < CH_COUNT; c++) begin : g_chan
      always_ff @(posedge ref_clk or posedge rst) begin
         if (rst) begin
            lcr[c] <= LCR_RESET;
         end else if (ioWr && chanHit(ioAddr, CH_BASE[c], OFS_LCR)) begin
            lcr[c] <= ioWrData; // RULE_10 RULE_14
         end
      end

      always_ff @(posedge ref_clk or posedge rst) begin
         if (rst) begin
            divLo[c] <= DIV_RESET;
         end else if (ioWr && divisor_latch_access[c] && chanHit(ioAddr, CH_BASE[c], OFS_DIV_LO)) begin
            divLo[c] <= ioWrData; // RULE_11
         end
      end

      always_ff @(posedge ref_clk or posedge rst) begin
         if (rst) begin
            divHi[c] <= DIV_RESET;
         end else if (ioWr && divisor_latch_access[c] && chanHit(ioAddr, CH_BASE[c], OFS_DIV_HI)) begin
            divHi[c] <= ioWrData; // RULE_11
         end
      end

      assign divisor_latch_access[c] = lcr[c][LCR_DIVISOR_LATCH_ACCESS_BIT];
      assign lineFormat[c] = lcr[c];

      baud_tick_gen u_baud (
         .ref_clk(ref_clk),
         .rst(rst),
         .divisor({divHi[c], divLo[c]}),
         .highSpeed(cfg.highSpeed[c]),
         .sampleTick(sampleTick[c])
      );
   end

   // ***************
   // Read path
   // ***************
   always_comb begin
      rdMux = RD_UNMAPPED;
      if (ioAddr == CFG_INDEX_PORT) begin
         rdMux = cfg.active ? cfg.indexVal : RD_UNMAPPED;
      end else if (ioAddr == CFG_DATA_PORT) begin
         rdMux = cfg.rdData; // RULE_06
      end
      for (int k = 0; k < CH_COUNT; k++) begin
         if (chanHit(ioAddr, CH_BASE[k], OFS_LCR)) begin
            rdMux = lcr[k];
         end
         if (chanHit(ioAddr, CH_BASE[k], OFS_DIV_LO)) begin
            rdMux = divisor_latch_access[k] ? divLo[k] : RD_EMPTY; // RULE_11 RULE_14
         end
         if (chanHit(ioAddr, CH_BASE[k], OFS_DIV_HI)) begin
            rdMux = divisor_latch_access[k] ? divHi[k] : RD_EMPTY; // RULE_11
         end
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ioRdData <= RD_EMPTY;
      end else if (ioRd) begin
         ioRdData <= rdMux;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ioRdValid <= 1'b0;
      end else begin
         ioRdValid <= ioRd;
      end
   end

   // ***************
   // Checks
   // ***************
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);

   a_enter_key: assert property (!configActive && ioWr && ioAddr == CFG_INDEX_PORT // RULE_03
      && ioWrData == KEY_ENTER |=> configActive)
      else $error("enter key ignored");
   a_divisor_latch_access_set: assert property (ioWr && ioAddr == CH_BASE[1] + 16'h0003 && ioWrData == 8'h80 // RULE_10
      |=> divisor_latch_access[1] && lineFormat[1] == 8'h80)
      else $error("access bit not set on channel four");
   a_div_write: assert property (ioWr && divisor_latch_access[0] && ioAddr == CH_BASE[0] // RULE_11
      |=> divLo[0] == $past(ioWrData) && $stable(divHi[0]))
      else $error("divisor low byte not written");
   a_div_locked: assert property (ioWr && !divisor_latch_access[0] && ioAddr == CH_BASE[0] + 16'h0001 // RULE_14
      |=> $stable(divHi[0]))
      else $error("divisor changed without access bit");
   a_read_answer: assert property (ioRd |=> ioRdValid ##1 (!ioRdValid || $past(ioRd)))
      else $error("read answer timing wrong");
   a_mode_readback: assert property (ioRd && ioAddr == CFG_DATA_PORT |=> ioRdData == $past(cfg.rdData)) // RULE_06
      else $error("data port read wrong");
   a_hs_path: assert property (highSpeedEn[0] && divHi[0] == 8'h80 && divLo[0] == 8'h01 // RULE_07
      && $stable(divLo[0]) && $stable(highSpeedEn[0]) && sampleTick[0] |-> ##[1:4] sampleTick[0])
      else $error("high speed tick rate wrong");
   c_config_enter: cover property (ioWr && ioAddr == CFG_INDEX_PORT && ioWrData == KEY_ENTER ##1 configActive);
   c_hs_channel: cover property (highSpeedEn[1] && sampleTick[1]);
endmodule

//--- design/uart_hs_pkg.sv
// Constants, register map and timing for the high-speed baud configuration block.
// Assumes one 25 MHz clock and a host doing single-cycle I/O port strobes.
//
// Contract
// RULE_01 - Channels three and four also run at 230400 and 460800 bps.
// RULE_02 - Host sets the high-speed bit and loads the special divisor.
// RULE_03 - Writing 55h to index port 3F0h enters configuration mode.
// RULE_04 - In configuration mode, index 07h selects the logical device number register.
// RULE_05 - Data port 3F1h value 04h selects channel three, 05h channel four.
// RULE_06 - Index F0h selects the mode register; data port reads return it.
// RULE_07 - Mode register bit D1 enables high speed for that channel.
// RULE_08 - A data port write with the mode register selected updates it.
// RULE_09 - Writing AAh to the index port leaves configuration mode.
// RULE_10 - Writing 80h to base plus three sets the divisor latch access bit.
// RULE_11 - With that bit set, offsets zero and one reach divisor low and high.
// RULE_12 - High speed with divisor 8002h gives 230400 bps.
// RULE_13 - High speed with divisor 8001h gives 460800 bps.
// RULE_14 - Host then rewrites the format with the access bit cleared.
// RULE_15 - Index and data writes outside configuration mode change nothing.
package uart_hs_pkg;
   // ***************
   // Bus and ports
   // ***************
   localparam int ADDR_W = 16;
   localparam int CH_COUNT = 2;
   localparam logic [15:0] CFG_INDEX_PORT = 16'h03F0;
   localparam logic [15:0] CFG_DATA_PORT = 16'h03F1;
   localparam logic [15:0] CH_BASE [CH_COUNT] = '{16'h03E8, 16'h02E8};
   localparam logic [2:0] OFS_DIV_LO = 3'h0;
   localparam logic [2:0] OFS_DIV_HI = 3'h1;
   localparam logic [2:0] OFS_LCR = 3'h3;
   localparam logic [7:0] RD_UNMAPPED = 8'hFF;
   localparam logic [7:0] RD_EMPTY = 8'h00;
   // ***************
   // Configuration keys and indexes
   // ***************
   localparam logic [7:0] KEY_ENTER = 8'h55;
   localparam logic [7:0] KEY_EXIT = 8'hAA;
   localparam logic [7:0] IDX_LDN = 8'h07;
   localparam logic [7:0] IDX_MODE = 8'hF0;
   localparam logic [7:0] LDN_CH3 = 8'h04;
   localparam logic [7:0] LDN_CH4 = 8'h05;
   localparam int MODE_HS_BIT = 1;
   localparam int LCR_DIVISOR_LATCH_ACCESS_BIT = 7;
   localparam int DIV_FAST_BIT = 15;
   localparam logic [7:0] MODE_RESET = 8'h00;
   localparam logic [7:0] LDN_RESET = 8'h00;
   localparam logic [7:0] LCR_RESET = 8'h00;
   localparam logic [7:0] DIV_RESET = 8'h00;
   // ***************
   // Baud timing
   // ***************
   localparam int CLK_HZ = 25_000_000;
   localparam int BASE_HZ = 1_843_200;
   localparam int ACC_GRAIN_HZ = 1_600;
   localparam int FAST_MULT = 4;
   localparam int ACC_W = 14;
   localparam logic [ACC_W:0] ACC_MOD = (ACC_W + 1)'(CLK_HZ / ACC_GRAIN_HZ);
   localparam logic [ACC_W:0] ACC_STEP_NORMAL = (ACC_W + 1)'(BASE_HZ / ACC_GRAIN_HZ);
   localparam logic [ACC_W:0] ACC_STEP_FAST = (ACC_W + 1)'(FAST_MULT * BASE_HZ / ACC_GRAIN_HZ);
endpackage

//--- tb/host_io_model.sv
// Host processor model: single-cycle I/O port reads and writes.
// Assumes the block takes strobes on the rising edge of ref_clk.
`timescale 1ns/1ps
module host_io_model (
   // Clock
   input wire logic ref_clk,
   // I/O port bus
   output logic [15:0] ioAddr,
   output logic [7:0] ioWrData,
   output logic ioWr,
   output logic ioRd,
   input wire logic [7:0] ioRdData,
   input wire logic ioRdValid
);
   initial begin
      ioAddr = 16'h0000;
      ioWrData = 8'h00;
      ioWr = 1'b0;
      ioRd = 1'b0;
   end
   // ***************
   // Bus cycles, released bus shows inverted value
   // ***************
   task automatic io_write(input logic [15:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      #1;
      ioAddr = a;
      ioWrData = d;
      ioWr = 1'b1;
      @(posedge ref_clk);
      #1;
      ioWr = 1'b0;
      ioAddr = ~a;
      ioWrData = ~d;
   endtask
   task automatic io_read(input logic [15:0] a, output logic [7:0] d, output logic ok);
      @(posedge ref_clk);
      #1;
      ioAddr = a;
      ioRd = 1'b1;
      @(posedge ref_clk);
      #1;
      ioRd = 1'b0;
      ioAddr = ~a;
      d = ioRdData;
      ok = ioRdValid;
   endtask
   // ***************
   // Configuration procedures
   // ***************
   task automatic set_high_speed(input logic [7:0] ldn);
      logic [7:0] v;
      logic ok;
      io_write(16'h03F0, 8'h55);
      io_write(16'h03F0, 8'h07);
      io_write(16'h03F1, ldn);
      io_write(16'h03F0, 8'hF0);
      io_read(16'h03F1, v, ok);
      io_write(16'h03F1, v | 8'h02);
      io_write(16'h03F0, 8'hAA);
   endtask
   task automatic load_divisor(input logic [15:0] base, input logic [15:0] dv, input logic [7:0] fmt);
      io_write(base + 16'h0003, 8'h80);
      io_write(base, dv[7:0]);
      io_write(base + 16'h0001, dv[15:8]);
      io_write(base + 16'h0003, fmt);
   endtask
endmodule

//--- tb/tb.sv
// Self-checking bench for the high-speed baud configuration block.
// Assumes host_io_model drives the I/O port bus.
`timescale 1ns/1ps
module tb;
   typedef struct {logic rd; logic [15:0] a; logic [7:0] d;} row_t;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic [15:0] ioAddr;
   logic [7:0] ioWrData;
   logic ioWr;
   logic ioRd;
   logic [7:0] ioRdData;
   logic ioRdValid;
   logic [1:0] sampleTick;
   logic [1:0] highSpeedEn;
   logic [1:0][7:0] lineFormat;
   logic configActive;
   logic [7:0] got;
   logic ok;
   int fail_count = 0;
   int total_checks = 0;
   int c3;
   int c4;
   row_t rows[28] = '{
      '{1'b1, 16'h03F1, 8'hFF},
      '{1'b0, 16'h03F0, 8'h07},
      '{1'b0, 16'h03F0, 8'h55},
      '{1'b0, 16'h03F0, 8'h07},
      '{1'b1, 16'h03F0, 8'h07},
      '{1'b1, 16'h03F1, 8'h00},
      '{1'b0, 16'h03F1, 8'h04},
      '{1'b1, 16'h03F1, 8'h04},
      '{1'b0, 16'h03F0, 8'hF0},
      '{1'b1, 16'h03F1, 8'h00},
      '{1'b0, 16'h03F1, 8'hA2},
      '{1'b1, 16'h03F1, 8'hA2},
      '{1'b0, 16'h03F0, 8'hAA},
      '{1'b1, 16'h03F0, 8'hFF},
      '{1'b0, 16'h03F1, 8'h00},
      '{1'b1, 16'h03E8, 8'h00},
      '{1'b0, 16'h03E8, 8'h55},
      '{1'b0, 16'h03EB, 8'h80},
      '{1'b1, 16'h03EB, 8'h80},
      '{1'b1, 16'h03E8, 8'h00},
      '{1'b0, 16'h03E8, 8'h01},
      '{1'b0, 16'h03E9, 8'h80},
      '{1'b1, 16'h03E8, 8'h01},
      '{1'b1, 16'h03E9, 8'h80},
      '{1'b0, 16'h03EB, 8'h03},
      '{1'b1, 16'h03E8, 8'h00},
      '{1'b1, 16'h03EA, 8'hFF},
      '{1'b1, 16'h0100, 8'hFF}
   };
   always #20 ref_clk = ~ref_clk;
   uart_high_speed_baud_config u_dut (
      .ref_clk(ref_clk),
      .rst(rst),
      .ioAddr(ioAddr),
      .ioWrData(ioWrData),
      .ioWr(ioWr),
      .ioRd(ioRd),
      .ioRdData(ioRdData),
      .ioRdValid(ioRdValid),
      .sampleTick(sampleTick),
      .highSpeedEn(highSpeedEn),
      .lineFormat(lineFormat),
      .configActive(configActive)
   );
   host_io_model u_host (
      .ref_clk(ref_clk),
      .ioAddr(ioAddr),
      .ioWrData(ioWrData),
      .ioWr(ioWr),
      .ioRd(ioRd),
      .ioRdData(ioRdData),
      .ioRdValid(ioRdValid)
   );
   // ***************
   // Compare and report
   // ***************
   task automatic chk8(input string n, input logic [7:0] g, input logic [7:0] e);
      total_checks++;
      if (g !== e) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic chk_cnt(input string n, input int e, input int g);
      total_checks++;
      if (g < e - 3 || g > e + 3) begin
         fail_count++;
         $display("[ERR] %s expected %0d seen %0d", n, e, g);
      end
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   initial begin
      #2_000_000;
      fail_count++;
      stop_test();
   end
   // ***************
   // Main sequence
   // ***************
   initial begin
      repeat (10) @(posedge ref_clk);
      #1;
      chk8("resetState", {configActive, ioRdValid, highSpeedEn, 4'h0}, 8'h00);
      chk8("resetRdData", ioRdData, 8'h00);
      rst = 1'b0;
      foreach (rows[i]) begin
         if (rows[i].rd) begin
            u_host.io_read(rows[i].a, got, ok);
            chk8("rdValid", {7'h00, ok}, 8'h01);
            chk8("rdData", got, rows[i].d);
         end else begin
            u_host.io_write(rows[i].a, rows[i].d);
         end
      end
      chk8("highSpeedEn", {6'h00, highSpeedEn}, 8'h01);
      u_host.set_high_speed(8'h05);
      chk8("highSpeedEn", {6'h00, highSpeedEn}, 8'h03);
      u_host.load_divisor(16'h02E8, 16'h8002, 8'h03);
      chk8("lineFormat3", lineFormat[0], 8'h03);
      chk8("lineFormat4", lineFormat[1], 8'h03);
      chk8("configActive", {7'h00, configActive}, 8'h00);
      u_host.io_write(16'h03F0, 8'h55);
      chk8("configActive", {7'h00, configActive}, 8'h01);
      u_host.io_write(16'h03F0, 8'hAA);
      chk8("configActive", {7'h00, configActive}, 8'h00);
      c3 = 0;
      c4 = 0;
      repeat (10000) begin
         @(posedge ref_clk);
         #1;
         c3 += int'(sampleTick[0]);
         c4 += int'(sampleTick[1]);
      end
      chk_cnt("ticks460800", 460800 * 16 / 2500, c3);
      chk_cnt("ticks230400", 230400 * 16 / 2500, c4);
      @(posedge ref_clk);
      #1;
      rst = 1'b1;
      #1;
      chk8("midReset", {configActive, highSpeedEn, 5'h00}, 8'h00);
      chk8("midResetFmt", lineFormat[0] | lineFormat[1], 8'h00);
      repeat (2) @(posedge ref_clk);
      #1;
      rst = 1'b0;
      u_host.io_read(16'h03F1, got, ok);
      chk8("lockedAfterReset", got, 8'hFF);
      u_host.load_divisor(16'h03E8, 16'h0001, 8'h03);
      c3 = 0;
      c4 = 0;
      repeat (1000) begin
         @(posedge ref_clk);
         #1;
         c3 += int'(sampleTick[0]);
         c4 += int'(sampleTick[1]);
      end
      chk_cnt("ticks115200", 115200 * 16 / 25000, c3);
      chk_cnt("ticksIdle", 0, c4);
      stop_test();
   end
endmodule
